// [inc/ppm_pkg.sv]
// Operation
// - Power-saving enable is bit 10 of control register 1Fh.
// - Power-saving acts only with auto-negotiation on and no link.
// - Power-saving keeps only transmitter, energy detect and PLL powered.
// - Power-saving enable resets to disabled.
// - Energy-detect power-down enabled by zero in bit 11 of 18h.
// - Energy-detect power-down acts only with auto-negotiation on and no link.
// - Bit 4 of 10h turns PLL off during energy-detect power-down.
// - Link pulses keep going periodically during energy-detect power-down.
// - Energy-detect power-down resets to disabled.
// - Bit 11 of register 0h set to one enters power-down.
// - Power-down disables everything except the management interface; crystal input stays enabled here unless bit 5 of 11h is set.
// - Clearing bit 11 of register 0h leaves power-down.
// - Bit 5 of 11h swaps crystal input for slow oscillator.
// - Slow oscillator with power-down gives lowest power state.
package ppm_pkg;
  localparam logic [4:0] PPM_REG_BASIC = 5'h00;
  localparam logic [4:0] PPM_REG_PLLCTL = 5'h10;
  localparam logic [4:0] PPM_REG_OSCCTL = 5'h11;
  localparam logic [4:0] PPM_REG_EDCTL = 5'h18;
  localparam logic [4:0] PPM_REG_PHYCTL2 = 5'h1F;
  localparam int PPM_BIT_SWRESET = 15;
  localparam int PPM_BIT_PWRDOWN = 11;
  localparam int PPM_BIT_PLLOFF = 4;
  localparam int PPM_BIT_SLOWOSC = 5;
  localparam int PPM_BIT_ENERGY_DETECT_POWERDOWN_N = 11;
  localparam int PPM_BIT_PSAVE = 10;
  localparam logic PPM_RST_PSAVE = 1'b0;
  localparam logic PPM_RST_ENERGY_DETECT_POWERDOWN_N = 1'b1;
  localparam logic PPM_RST_PWRDOWN = 1'b0;
  localparam logic PPM_RST_SLOWOSC = 1'b0;
  localparam logic PPM_RST_PLLOFF = 1'b0;
  localparam int PPM_CLK_MHZ = 50;
  localparam int PPM_PULSE_MS = 16;
  localparam int PPM_PULSE_CYC = PPM_PULSE_MS * 1000 * PPM_CLK_MHZ;
  localparam int PPM_SWRST_CYC = 4;
  typedef enum logic [2:0] {
    PPM_ST_NORMAL, PPM_ST_PSAVE, PPM_ST_ENERGY_DETECT_POWERDOWN, PPM_ST_PDOWN, PPM_ST_WAKE
  } ppm_state_t;
endpackage

// [verilog/ppm_pulse_timer.sv]
`timescale 1ns/1ps
module ppm_pulse_timer #(
  parameter int PERIOD = 800000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic run,
  output logic pulse
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic pulse_next;
  always_comb begin
    cnt_next = 32'h0;
    pulse_next = 1'b0;
    if (run) begin
      if (cnt_reg >= 32'(PERIOD - 1)) begin
        pulse_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 32'h1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_reg <= 32'h0;
      pulse <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse <= pulse_next;
    end
  end
endmodule

// [verilog/ppm_swreset.sv]
`timescale 1ns/1ps
module ppm_swreset
  import ppm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  output logic active
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = 4'(PPM_SWRST_CYC);
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign active = (cnt_reg != 4'h0);
endmodule

// [verilog/ppm_power_ctrl.sv]
`timescale 1ns/1ps
module ppm_power_ctrl
  import ppm_pkg::*;
#(
  parameter int PULSE_CYC = PPM_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic autoneg_en,
  input wire logic link_up,
  input wire logic energy_detected,
  output logic psave_en,
  output logic energy_detect_powerdown_n,
  output logic pll_auto_off,
  output logic pwr_down,
  output logic slow_osc_sel,
  output logic sw_reset_bit,
  output logic core_pwr_on,
  output logic tx_pwr_on,
  output logic energy_det_pwr_on,
  output logic pll_pwr_on,
  output logic crystal_input_en,
  output logic mgmt_active,
  output logic link_pulse,
  output logic internal_reset,
  output ppm_pkg::ppm_state_t power_state
);
  import ppm_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic psave_reg, psave_next;
  logic energy_detect_powerdown_n_reg, energy_detect_powerdown_n_next;
  logic plloff_reg, plloff_next;
  logic pdown_reg, pdown_next;
  logic slow_reg, slow_next;
  logic swrst_start;
  logic swrst_active;
  logic pulse_raw;
  ppm_state_t st_reg, st_next;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    return a == r;
  endfunction

  assign swrst_start = wr_en && hit(wr_addr, PPM_REG_BASIC) && wr_data[PPM_BIT_SWRESET];

  ppm_swreset u_swrst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(swrst_start),
    .active(swrst_active)
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    psave_next = psave_reg;
    energy_detect_powerdown_n_next = energy_detect_powerdown_n_reg;
    plloff_next = plloff_reg;
    pdown_next = pdown_reg;
    slow_next = slow_reg;
    if (swrst_active) begin
      psave_next = PPM_RST_PSAVE;
      energy_detect_powerdown_n_next = PPM_RST_ENERGY_DETECT_POWERDOWN_N;
      plloff_next = PPM_RST_PLLOFF;
      pdown_next = PPM_RST_PWRDOWN;
      slow_next = PPM_RST_SLOWOSC;
    end else if (wr_en) begin
      unique case (wr_addr)
        PPM_REG_BASIC: pdown_next = wr_data[PPM_BIT_PWRDOWN];
        PPM_REG_PLLCTL: plloff_next = wr_data[PPM_BIT_PLLOFF];
        PPM_REG_OSCCTL: slow_next = wr_data[PPM_BIT_SLOWOSC];
        PPM_REG_EDCTL: energy_detect_powerdown_n_next = wr_data[PPM_BIT_ENERGY_DETECT_POWERDOWN_N];
        PPM_REG_PHYCTL2: psave_next = wr_data[PPM_BIT_PSAVE];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic idle_ok;
    idle_ok = 1'b0;
    idle_ok = autoneg_en && !link_up;
    st_next = st_reg;
    // Power-down follows the written bit in the same cycle as its mirror output
    unique case (st_reg)
      PPM_ST_NORMAL: begin
        if (pdown_next) begin
          st_next = PPM_ST_PDOWN;
        end else if (idle_ok && !energy_detect_powerdown_n_reg && !energy_detected) begin
          st_next = PPM_ST_ENERGY_DETECT_POWERDOWN;
        end else if (idle_ok && psave_reg && !energy_detected) begin
          st_next = PPM_ST_PSAVE;
        end
      end
      PPM_ST_PSAVE, PPM_ST_ENERGY_DETECT_POWERDOWN: begin
        if (pdown_next) begin
          st_next = PPM_ST_PDOWN;
        end else if (energy_detected || !idle_ok) begin
          st_next = PPM_ST_WAKE;
        end else if (st_reg == PPM_ST_PSAVE && !energy_detect_powerdown_n_reg) begin
          // Energy-detect power-down outranks power-saving when both are on
          st_next = PPM_ST_ENERGY_DETECT_POWERDOWN;
        end else if (st_reg == PPM_ST_PSAVE && !psave_reg) begin
          st_next = PPM_ST_NORMAL;
        end else if (st_reg == PPM_ST_ENERGY_DETECT_POWERDOWN && energy_detect_powerdown_n_reg) begin
          st_next = PPM_ST_NORMAL;
        end
      end
      PPM_ST_PDOWN: if (!pdown_next) st_next = PPM_ST_NORMAL;
      // Wake holds one cycle so the analog blocks restart before re-entry
      PPM_ST_WAKE: st_next = pdown_next ? PPM_ST_PDOWN : PPM_ST_NORMAL;
      default: st_next = PPM_ST_NORMAL;
    endcase
    if (swrst_active) begin
      st_next = PPM_ST_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Periodic link pulses
  ppm_pulse_timer #(
    .PERIOD(PULSE_CYC)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(st_reg == PPM_ST_ENERGY_DETECT_POWERDOWN),
    .pulse(pulse_raw)
  );

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      psave_reg <= PPM_RST_PSAVE;
      energy_detect_powerdown_n_reg <= PPM_RST_ENERGY_DETECT_POWERDOWN_N;
      plloff_reg <= PPM_RST_PLLOFF;
      pdown_reg <= PPM_RST_PWRDOWN;
      slow_reg <= PPM_RST_SLOWOSC;
      st_reg <= PPM_ST_NORMAL;
    end else begin
      psave_reg <= psave_next;
      energy_detect_powerdown_n_reg <= energy_detect_powerdown_n_next;
      plloff_reg <= plloff_next;
      pdown_reg <= pdown_next;
      slow_reg <= slow_next;
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      psave_en <= PPM_RST_PSAVE;
      energy_detect_powerdown_n <= PPM_RST_ENERGY_DETECT_POWERDOWN_N;
      pll_auto_off <= PPM_RST_PLLOFF;
      pwr_down <= PPM_RST_PWRDOWN;
      slow_osc_sel <= PPM_RST_SLOWOSC;
      sw_reset_bit <= 1'b0;
      core_pwr_on <= 1'b1;
      tx_pwr_on <= 1'b1;
      energy_det_pwr_on <= 1'b1;
      pll_pwr_on <= 1'b1;
      crystal_input_en <= 1'b1;
      mgmt_active <= 1'b1;
      link_pulse <= 1'b0;
      internal_reset <= 1'b0;
      power_state <= PPM_ST_NORMAL;
    end else begin
      psave_en <= psave_next;
      energy_detect_powerdown_n <= energy_detect_powerdown_n_next;
      pll_auto_off <= plloff_next;
      pwr_down <= pdown_next;
      slow_osc_sel <= slow_next;
      sw_reset_bit <= swrst_active || swrst_start;
      core_pwr_on <= (st_next == PPM_ST_NORMAL) || (st_next == PPM_ST_WAKE);
      tx_pwr_on <= (st_next != PPM_ST_PDOWN);
      energy_det_pwr_on <= (st_next != PPM_ST_PDOWN);
      pll_pwr_on <= !(st_next == PPM_ST_PDOWN || (st_next == PPM_ST_ENERGY_DETECT_POWERDOWN && plloff_next));
      crystal_input_en <= !slow_next;
      mgmt_active <= 1'b1;
      link_pulse <= pulse_raw && (st_reg == PPM_ST_ENERGY_DETECT_POWERDOWN);
      internal_reset <= swrst_active || swrst_start;
      power_state <= st_next;
    end
  end
endmodule

// [bench/ppm_power_ctrl_monitor.sv]
`timescale 1ns/1ps
module ppm_power_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic link_up,
  input wire logic psave_en,
  input wire logic energy_detect_powerdown_n,
  input wire logic pll_auto_off,
  input wire logic pwr_down,
  input wire logic slow_osc_sel,
  input wire logic sw_reset_bit,
  input wire logic core_pwr_on,
  input wire logic tx_pwr_on,
  input wire logic energy_det_pwr_on,
  input wire logic pll_pwr_on,
  input wire logic crystal_input_en,
  input wire logic mgmt_active,
  input wire logic link_pulse,
  input ppm_pkg::ppm_state_t power_state
);
  import ppm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Writes during a soft reset are dropped, so they prove nothing
  wire take = wr_en && !sw_reset_bit;
  psave_bit_a: assert property (
    take && wr_addr == PPM_REG_PHYCTL2 |=> psave_en == $past(wr_data[10]))
    else $error("power-saving enable not taken");
  energy_detect_powerdown_bit_a: assert property (
    take && wr_addr == PPM_REG_EDCTL |=> energy_detect_powerdown_n == $past(wr_data[11]))
    else $error("energy-detect enable not taken");
  pdown_on_a: assert property (
    take && wr_addr == PPM_REG_BASIC && wr_data[11] && !wr_data[15]
    |=> pwr_down && power_state == PPM_ST_PDOWN)
    else $error("power-down not entered");
  pdown_off_a: assert property (
    take && wr_addr == PPM_REG_BASIC && !wr_data[11] |=> !pwr_down)
    else $error("power-down not left");
  pdown_keep_a: assert property (
    power_state == PPM_ST_PDOWN |-> mgmt_active && !core_pwr_on && !tx_pwr_on)
    else $error("power-down enables wrong");
  psave_pwr_a: assert property (
    power_state == PPM_ST_PSAVE |-> tx_pwr_on && energy_det_pwr_on && pll_pwr_on && !core_pwr_on)
    else $error("power-saving enables wrong");
  pll_off_a: assert property (
    power_state == PPM_ST_ENERGY_DETECT_POWERDOWN && pll_auto_off && $past(pll_auto_off)
    |-> !pll_pwr_on && tx_pwr_on && energy_det_pwr_on)
    else $error("pll not off in energy-detect power-down");
  link_block_a: assert property (
    link_up [*3] |-> power_state != PPM_ST_PSAVE && power_state != PPM_ST_ENERGY_DETECT_POWERDOWN)
    else $error("low-power state with link present");
  swr_clear_a: assert property ($rose(sw_reset_bit) |-> ##[1:8] !sw_reset_bit)
    else $error("soft reset did not clear");
  osc_sel_a: assert property (slow_osc_sel && $past(slow_osc_sel) |-> !crystal_input_en)
    else $error("crystal input still on");
  cover property (power_state == PPM_ST_PSAVE);
  cover property (power_state == PPM_ST_ENERGY_DETECT_POWERDOWN && link_pulse);
  cover property (power_state == PPM_ST_PDOWN && slow_osc_sel);
endmodule
bind ppm_power_ctrl ppm_power_ctrl_monitor ppm_power_ctrl_monitor_inst (.*);

// [bench/ppm_mgmt_model.sv]
`timescale 1ns/1ps
module ppm_mgmt_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [4:0] addr,
  input wire logic [15:0] data,
  output logic wr_en = 1'b0,
  output logic [4:0] wr_addr = 5'h00,
  output logic [15:0] wr_data = 16'h0000
);
  // Idle bus keeps toggling so a stale address or word is never mistaken for a write
  always @(posedge sys_clk) begin
    wr_en <= go;
    wr_addr <= go ? addr : ~wr_addr;
    wr_data <= go ? data : ~wr_data;
  end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import ppm_pkg::*;
  localparam int PULSE_CYC = 20;
  logic sys_clk = 0, rstn = 0, go = 0, autoneg_en = 1, link_up = 0, energy_detected = 0;
  logic [4:0] addr = 5'h00, wr_addr;
  logic [15:0] data = 16'h0000, wr_data, r;
  logic wr_en, psave_en, energy_detect_powerdown_n, pll_auto_off, pwr_down, slow_osc_sel;
  logic sw_reset_bit, core_pwr_on, tx_pwr_on, energy_det_pwr_on, pll_pwr_on;
  logic crystal_input_en, mgmt_active, link_pulse, internal_reset;
  ppm_state_t power_state;
  int err_total = 0, n_checks = 0, i;
  ppm_mgmt_model ppm_mgmt_model_inst (.*);
  ppm_power_ctrl #(.PULSE_CYC(PULSE_CYC)) ppm_power_ctrl_inst (.*);
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    go <= 1'b1;
    addr <= a;
    data <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wt(input ppm_state_t s, input int n);
    for (i = 0; i < n && power_state !== s; i++) @(posedge sys_clk);
    chk("power_state", 16'(s), 16'(power_state));
    if (power_state !== s) results();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    r = 16'($urandom(32));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("psave_en", 0, psave_en);
    chk("energy_detect_powerdown_n", 1, energy_detect_powerdown_n);
    wr(PPM_REG_PHYCTL2, 16'h0400);
    chk("psave_en", 1, psave_en);
    wt(PPM_ST_PSAVE, 8);
    chk("psave_pwr", 4'b0111, {core_pwr_on, tx_pwr_on, energy_det_pwr_on, pll_pwr_on});
    energy_detected <= 1'b1;
    wt(PPM_ST_NORMAL, 8);
    energy_detected <= 1'b0;
    wt(PPM_ST_PSAVE, 8);
    link_up <= 1'b1;
    wt(PPM_ST_NORMAL, 8);
    link_up <= 1'b0;
    wt(PPM_ST_PSAVE, 8);
    autoneg_en <= 1'b0;
    wt(PPM_ST_NORMAL, 8);
    autoneg_en <= 1'b1;
    wr(PPM_REG_EDCTL, 16'h0000);
    chk("energy_detect_powerdown_n", 0, energy_detect_powerdown_n);
    wt(PPM_ST_ENERGY_DETECT_POWERDOWN, 8);
    wr(PPM_REG_PLLCTL, 16'h0010);
    chk("energy_detect_powerdown_pwr", 3'b110, {tx_pwr_on, energy_det_pwr_on, pll_pwr_on});
    for (i = 0; i < PULSE_CYC + 4 && link_pulse !== 1'b1; i++) @(posedge sys_clk);
    chk("link_pulse", 1, link_pulse);
    if (link_pulse !== 1'b1) results();
    energy_detected <= 1'b1;
    wt(PPM_ST_NORMAL, 8);
    energy_detected <= 1'b0;
    wr(PPM_REG_BASIC, 16'h0800);
    wt(PPM_ST_PDOWN, 0);
    chk("pdown_pwr", 3'b100, {mgmt_active, core_pwr_on, tx_pwr_on});
    wr(PPM_REG_OSCCTL, 16'h0020);
    chk("crystal", 0, crystal_input_en);
    chk("slow_osc_sel", 1, slow_osc_sel);
    wt(PPM_ST_PDOWN, 0);
    // Exit order: oscillator, then power-down, then soft reset
    wr(PPM_REG_OSCCTL, 16'h0000);
    chk("crystal", 1, crystal_input_en);
    wr(PPM_REG_BASIC, 16'h0000);
    chk("pwr_down", 0, pwr_down);
    wr(PPM_REG_BASIC, 16'h8000);
    chk("sw_reset", 1, sw_reset_bit);
    chk("internal_reset", 1, internal_reset);
    for (i = 0; i < 10 && sw_reset_bit !== 1'b0; i++) @(posedge sys_clk);
    chk("sw_reset", 0, sw_reset_bit);
    if (sw_reset_bit !== 1'b0) results();
    chk("internal_reset", 0, internal_reset);
    chk("defaults", 3'b010, {psave_en, energy_detect_powerdown_n, pll_auto_off});
    repeat (20) begin
      r = 16'($urandom);
      wr(PPM_REG_PHYCTL2, r);
      chk("psave_en", 16'(r[10]), 16'(psave_en));
      wr(PPM_REG_EDCTL, r);
      chk("energy_detect_powerdown_n", 16'(r[11]), 16'(energy_detect_powerdown_n));
      // An unmapped register must leave the power-saving enable bit alone
      wr(5'h05, ~r);
      chk("psave_en", 16'(r[10]), 16'(psave_en));
    end
    results();
  end
endmodule
